// >>> design/jllt_pkg.sv
// Purpose: shared constants and types for the 8b/10b link receive controller
// Assumes: characters arrive already decoded from the 10-bit line code
// Notes: control characters are flagged by is_k beside the octet value
package jllt_pkg;

    // ************************************************************
    // control characters (octet value with is_k set)
    // ************************************************************
    localparam logic [7:0] CHAR_COMMA = 8'hBC;   // K28.5
    localparam logic [7:0] CHAR_ILAS_START = 8'h1C;   // K28.0
    localparam logic [7:0] CHAR_MF_ALIGN = 8'h7C;   // K28.3
    localparam logic [7:0] CHAR_FR_ALIGN = 8'hFC;   // K28.7

    // ************************************************************
    // link bring-up and monitoring counts
    // ************************************************************
    localparam int CGS_COMMAS = 4;
    localparam int ILAS_MULTIFRAMES = 4;
    localparam int K_MAX = 256;
    localparam int FK_MAX = 1024;
    localparam int FK_MIN = 17;

    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic is_k;
        logic [7:0] octet;
    } jllt_char_t;

    typedef enum logic [2:0] {
        ST_WAIT_SYSREF = 3'h0,
        ST_CGS = 3'h1,
        ST_SYNC_REL = 3'h2,
        ST_ILAS = 3'h3,
        ST_DATA = 3'h4
    } jllt_state_t;

endpackage

// >>> design/jllt_rx_ctrl.sv
// Purpose: 8b/10b link receive controller facing a converter transmitter
// Assumes: lane characters decoded and on i_sys_clk, one per lane per cycle
// Notes: i_sysref is a pin and is synchronised before use
// Contract
// - frames per multiframe K lies in ceil(17/F)..min(256, floor(1024/F))
// - each end resets its multiframe counter on captured sysref
// - continuous sysref runs at multiframe rate or an integer division
// - receiver drives sync low to request link start after sysref
// - code group sync declared after four consecutive K28.5 characters
// - after code group sync, release sync at next multiframe edge
// - lanes buffered from first K28.0, released together at safe point
// - unscrambled: alignment character replaced by previous frame-last octet
// - scrambled: K28.7 restored to FC and K28.3 to 7C
// - alignment characters must sit at frame or multiframe end
// - error flagged when alignment characters misplaced or missing
// - on misalignment drop sync and ask for sysref again first; code does so only at the ERR_LIMIT-th alignment error in the data state
module jllt_rx_ctrl #(
    parameter int LANES = 2,
    parameter int F = 2,
    parameter int K = 16,
    parameter int BUF_DEPTH = 64,
    parameter int ERR_LIMIT = 4
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_sysref,
    input wire logic i_scramble_enable,
    input wire jllt_pkg::jllt_char_t [LANES-1:0] i_rx_char,
    output logic o_sync_n,
    output logic o_sysref_req,
    output logic o_link_up,
    output logic o_valid,
    output logic [LANES-1:0][7:0] o_data,
    output logic o_frame_end,
    output logic o_mf_end,
    output logic o_align_err
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    localparam int FK = F * K;
    localparam int LW = $clog2(FK);
    localparam int PW = $clog2(BUF_DEPTH);
    localparam int OW = (F > 1) ? $clog2(F) : 1;
    localparam int KW = $clog2(K);
    localparam int EW = $clog2(ERR_LIMIT + 1);

    initial begin
        if (F < 1 || K > jllt_pkg::K_MAX || FK > jllt_pkg::FK_MAX ||
            FK < jllt_pkg::FK_MIN) begin
            $error("frames per multiframe out of range");
        end
        if (BUF_DEPTH < FK || (1 << PW) != BUF_DEPTH || LANES < 1 ||
            K < 2 || ERR_LIMIT < 1) begin
            $error("unsupported buffer or lane parameters");
        end
    end

    localparam logic [LW-1:0] FK_LAST = LW'(FK - 1);
    localparam logic [OW-1:0] F_LAST = OW'(F - 1);
    localparam logic [KW-1:0] K_LAST = KW'(K - 1);
    localparam logic [1:0] ILAS_LAST = 2'(jllt_pkg::ILAS_MULTIFRAMES - 1);
    localparam logic [EW-1:0] ERR_LAST = EW'(ERR_LIMIT - 1);

    // ************************************************************
    // sysref capture and local multiframe counter
    // ************************************************************
    logic sysref_meta_r;
    logic sysref_sync_r;
    logic sysref_prev_r;
    logic sysref_rise;
    logic [LW-1:0] lmfc_cnt_r, lmfc_cnt_nxt;
    logic lmfc_valid_r, lmfc_valid_nxt;
    logic lmfc_edge;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            sysref_meta_r <= 1'b0;
            sysref_sync_r <= 1'b0;
            sysref_prev_r <= 1'b0;
        end else begin
            sysref_meta_r <= i_sysref;
            sysref_sync_r <= sysref_meta_r;
            sysref_prev_r <= sysref_sync_r;
        end
    end

    assign sysref_rise = sysref_sync_r & ~sysref_prev_r;
    assign lmfc_edge = lmfc_valid_r && (lmfc_cnt_r == '0);

    // ************************************************************
    // link state
    // ************************************************************
    jllt_pkg::jllt_state_t state_r, state_nxt;
    logic sync_n_r, sync_n_nxt;
    logic sysref_req_r, sysref_req_nxt;
    logic released_r, released_nxt;
    logic [PW-1:0] rd_ptr_r, rd_ptr_nxt;
    logic [OW-1:0] oct_r, oct_nxt;
    logic [KW-1:0] frm_r, frm_nxt;
    logic [1:0] ilas_mf_r, ilas_mf_nxt;
    logic [EW-1:0] err_cnt_r, err_cnt_nxt;
    logic end_frame;
    logic end_mf;
    logic in_data;
    logic [LANES-1:0] cgs_ok;
    logic [LANES-1:0] started;
    logic [LANES-1:0] lane_err;
    logic [LANES-1:0][7:0] lane_out;

    assign end_frame = (oct_r == F_LAST);
    assign end_mf = end_frame && (frm_r == K_LAST);
    assign in_data = (state_r == jllt_pkg::ST_DATA);

    always_comb begin
        state_nxt = state_r;
        sync_n_nxt = sync_n_r;
        sysref_req_nxt = 1'b0;
        released_nxt = released_r;
        rd_ptr_nxt = rd_ptr_r;
        oct_nxt = oct_r;
        frm_nxt = frm_r;
        ilas_mf_nxt = ilas_mf_r;
        err_cnt_nxt = err_cnt_r;
        lmfc_valid_nxt = lmfc_valid_r;
        lmfc_cnt_nxt = (lmfc_cnt_r == FK_LAST) ? '0 : lmfc_cnt_r + 1'b1;
        if (sysref_rise) begin
            lmfc_cnt_nxt = '0;
            lmfc_valid_nxt = 1'b1;
        end
        if (released_r) begin
            rd_ptr_nxt = rd_ptr_r + 1'b1;
            oct_nxt = end_frame ? '0 : oct_r + 1'b1;
            if (end_frame) begin
                frm_nxt = end_mf ? '0 : frm_r + 1'b1;
            end
        end
        unique case (state_r)
            jllt_pkg::ST_WAIT_SYSREF: begin
                released_nxt = 1'b0;
                if (lmfc_valid_r) begin
                    state_nxt = jllt_pkg::ST_CGS;
                    sync_n_nxt = 1'b0;
                end
            end
            jllt_pkg::ST_CGS: begin
                sync_n_nxt = 1'b0;
                if (&cgs_ok) begin
                    state_nxt = jllt_pkg::ST_SYNC_REL;
                end
            end
            jllt_pkg::ST_SYNC_REL: begin
                if (lmfc_edge) begin
                    state_nxt = jllt_pkg::ST_ILAS;
                    sync_n_nxt = 1'b1;
                end
            end
            jllt_pkg::ST_ILAS: begin
                if (!released_r && (&started) && lmfc_edge) begin
                    released_nxt = 1'b1;
                    rd_ptr_nxt = '0;
                    oct_nxt = '0;
                    frm_nxt = '0;
                    ilas_mf_nxt = '0;
                end
                if (released_r && end_mf) begin
                    ilas_mf_nxt = ilas_mf_r + 1'b1;
                    if (ilas_mf_r == ILAS_LAST) begin
                        state_nxt = jllt_pkg::ST_DATA;
                        err_cnt_nxt = '0;
                    end
                end
            end
            jllt_pkg::ST_DATA: begin
                if (|lane_err) begin
                    err_cnt_nxt = err_cnt_r + 1'b1;
                    if (err_cnt_r == ERR_LAST) begin
                        state_nxt = jllt_pkg::ST_WAIT_SYSREF;
                        sync_n_nxt = 1'b0;
                        sysref_req_nxt = 1'b1;
                        lmfc_valid_nxt = 1'b0;
                        released_nxt = 1'b0;
                    end
                end
            end
        endcase
        if (state_nxt == jllt_pkg::ST_WAIT_SYSREF &&
            state_r != jllt_pkg::ST_WAIT_SYSREF) begin
            lmfc_cnt_nxt = '0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            state_r <= jllt_pkg::ST_WAIT_SYSREF;
            sync_n_r <= 1'b1;
            sysref_req_r <= 1'b0;
            released_r <= 1'b0;
            rd_ptr_r <= '0;
            oct_r <= '0;
            frm_r <= '0;
            ilas_mf_r <= '0;
            err_cnt_r <= '0;
            lmfc_cnt_r <= '0;
            lmfc_valid_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            sync_n_r <= sync_n_nxt;
            sysref_req_r <= sysref_req_nxt;
            released_r <= released_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            oct_r <= oct_nxt;
            frm_r <= frm_nxt;
            ilas_mf_r <= ilas_mf_nxt;
            err_cnt_r <= err_cnt_nxt;
            lmfc_cnt_r <= lmfc_cnt_nxt;
            lmfc_valid_r <= lmfc_valid_nxt;
        end
    end

    // ************************************************************
    // per-lane sync, elastic buffer and alignment monitor
    // ************************************************************
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        jllt_pkg::jllt_char_t mem [BUF_DEPTH];
        jllt_pkg::jllt_char_t rx;
        jllt_pkg::jllt_char_t rd;
        logic [2:0] comma_r, comma_nxt;
        logic start_r, start_nxt;
        logic [PW-1:0] wr_ptr_r, wr_ptr_nxt;
        logic wr_en;
        logic [7:0] last_r, last_nxt;
        logic last_ok_r, last_ok_nxt;
        logic is_f;
        logic is_a;
        logic err;
        logic [7:0] outv;
        logic buffering;

        assign rx = i_rx_char[l];
        assign rd = mem[rd_ptr_r];
        assign buffering = (state_r == jllt_pkg::ST_ILAS) || in_data;
        assign is_f = rd.is_k && (rd.octet == jllt_pkg::CHAR_FR_ALIGN);
        assign is_a = rd.is_k && (rd.octet == jllt_pkg::CHAR_MF_ALIGN);

        always_comb begin
            comma_nxt = '0;
            if (rx.is_k && rx.octet == jllt_pkg::CHAR_COMMA) begin
                comma_nxt = (comma_r == 3'(jllt_pkg::CGS_COMMAS)) ?
                    comma_r : comma_r + 3'h1;
            end
            start_nxt = start_r;
            if (!buffering) begin
                start_nxt = 1'b0;
            end else if (rx.is_k && rx.octet == jllt_pkg::CHAR_ILAS_START) begin
                start_nxt = 1'b1;
            end
            wr_en = buffering && start_nxt;
            wr_ptr_nxt = wr_en ? wr_ptr_r + 1'b1 : '0;
        end

        always_comb begin
            outv = rd.octet;
            err = 1'b0;
            last_nxt = last_r;
            last_ok_nxt = in_data && last_ok_r;
            if (i_scramble_enable) begin
                if (is_f) begin
                    outv = jllt_pkg::CHAR_FR_ALIGN;
                    err = !end_frame;
                end else if (is_a) begin
                    outv = jllt_pkg::CHAR_MF_ALIGN;
                    err = !end_mf;
                end else if (rd.is_k) begin
                    err = 1'b1;
                end else if (end_mf && rd.octet == jllt_pkg::CHAR_MF_ALIGN) begin
                    err = 1'b1;
                end else if (end_frame &&
                             rd.octet == jllt_pkg::CHAR_FR_ALIGN) begin
                    err = 1'b1;
                end
            end else begin
                if (is_f) begin
                    outv = last_r;
                    err = !end_frame || end_mf || !last_ok_r;
                end else if (is_a) begin
                    outv = last_r;
                    err = !end_mf || !last_ok_r;
                end else if (rd.is_k) begin
                    err = 1'b1;
                end else if (end_frame && last_ok_r && rd.octet == last_r) begin
                    err = 1'b1;
                end
            end
            if (in_data && end_frame) begin
                last_nxt = outv;
                last_ok_nxt = 1'b1;
            end
            if (!in_data) begin
                err = 1'b0;
            end
        end

        assign lane_err[l] = err;
        assign lane_out[l] = outv;
        assign cgs_ok[l] = (comma_r == 3'(jllt_pkg::CGS_COMMAS));
        assign started[l] = start_r;

        always_ff @(posedge i_sys_clk) begin
            if (wr_en) begin
                mem[wr_ptr_r] <= rx;
            end
        end

        always_ff @(posedge i_sys_clk) begin
            if (!i_rstn) begin
                comma_r <= '0;
                start_r <= 1'b0;
                wr_ptr_r <= '0;
                last_r <= '0;
                last_ok_r <= 1'b0;
            end else begin
                comma_r <= comma_nxt;
                start_r <= start_nxt;
                wr_ptr_r <= wr_ptr_nxt;
                last_r <= last_nxt;
                last_ok_r <= last_ok_nxt;
            end
        end
    end

    // ************************************************************
    // registered data outputs
    // ************************************************************
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_valid <= 1'b0;
            o_data <= '0;
            o_frame_end <= 1'b0;
            o_mf_end <= 1'b0;
            o_align_err <= 1'b0;
        end else begin
            o_valid <= in_data;
            o_data <= in_data ? lane_out : '0;
            o_frame_end <= in_data && end_frame;
            o_mf_end <= in_data && end_mf;
            o_align_err <= |lane_err;
        end
    end

    assign o_sync_n = sync_n_r;
    assign o_sysref_req = sysref_req_r;
    assign o_link_up = in_data;

endmodule // jllt_rx_ctrl

// >>> testbench/jllt_rx_ctrl_properties.sv
// Purpose: port-level properties of the link receive controller
// Assumes: bound to jllt_rx_ctrl, one clock domain
// Notes: helper counters track comma runs, multiframe spacing and errors
module jllt_rx_ctrl_properties #(
    parameter int LANES = 2,
    parameter int F = 2,
    parameter int K = 16,
    parameter int ERR_LIMIT = 4
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_sysref,
    input wire logic i_scramble_enable,
    input wire jllt_pkg::jllt_char_t [LANES-1:0] i_rx_char,
    input wire logic o_sync_n,
    input wire logic o_sysref_req,
    input wire logic o_link_up,
    input wire logic o_valid,
    input wire logic [LANES-1:0][7:0] o_data,
    input wire logic o_frame_end,
    input wire logic o_mf_end,
    input wire logic o_align_err
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // helper state and properties
    // ************************************************************
    logic all_comma;
    logic seen_r, seen_nxt, link_r, link_nxt, mfs_r, mfs_nxt;
    logic [2:0] run_r, run_nxt;
    logic [15:0] mf_cnt_r, mf_cnt_nxt;
    logic [7:0] err_r, err_nxt;

    always_comb begin
        all_comma = 1'b1;
        for (int l = 0; l < LANES; l++) begin
            all_comma &= (i_rx_char[l] == {1'b1, jllt_pkg::CHAR_COMMA});
        end
        seen_nxt = seen_r | i_sysref;
        run_nxt = !all_comma ? 3'h0 : (run_r == 3'h4) ? 3'h4 : run_r + 3'h1;
        link_nxt = o_link_up;
        err_nxt = (o_link_up && !link_r) ? 8'h00 : err_r + 8'(o_align_err);
        mfs_nxt = o_valid && (mfs_r || o_mf_end);
        mf_cnt_nxt = (!o_valid || o_mf_end) ? 16'h0000 : mf_cnt_r + 16'h0001;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            {seen_r, link_r, mfs_r, run_r, mf_cnt_r, err_r} <= '0;
        end else begin
            {seen_r, link_r, mfs_r} <= {seen_nxt, link_nxt, mfs_nxt};
            {run_r, mf_cnt_r, err_r} <= {run_nxt, mf_cnt_nxt, err_nxt};
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);

    a_sync_needs_ref: assert property ($fell(o_sync_n) |-> seen_r)
        else $error("sync requested before any sysref");
    a_cgs_first: assert property ($rose(o_sync_n) |-> run_r == 3'h4)
        else $error("sync released without four commas");
    a_valid_link: assert property (o_valid |-> $past(o_link_up) && $past(o_sync_n))
        else $error("data valid outside the data state");
    a_mf_in_frame: assert property (o_mf_end |-> o_frame_end && o_valid)
        else $error("multiframe end not on a frame end");
    a_frame_gap: assert property (o_frame_end |=> !o_frame_end)
        else $error("frame ends closer than a frame");
    a_mf_period: assert property (o_mf_end && mfs_r |-> mf_cnt_r == 16'(F * K - 1))
        else $error("multiframe length wrong");
    a_err_limit: assert property (o_sysref_req |-> o_align_err && err_r == 8'(ERR_LIMIT - 1))
        else $error("realign not at the error limit");
    a_req_pulse: assert property (o_sysref_req |=> !o_sysref_req && !o_sync_n)
        else $error("sysref request not a single pulse");
    a_req_drop: assert property (o_sysref_req |-> !o_sync_n && !o_link_up)
        else $error("link kept up on realign");
endmodule // jllt_rx_ctrl_properties

// >>> testbench/jllt_tx_model.sv
// Purpose: converter transmitter model facing the link receive controller
// Assumes: characters handed over decoded, one per lane per cycle
// Notes: i_inject puts a frame alignment character at a frame start
module jllt_tx_model #(
    parameter int LANES = 2,
    parameter int F = 2,
    parameter int K = 16
) (
    input wire logic i_clk,
    input wire logic i_sysref,
    input wire logic i_sync_n,
    input wire logic i_scramble_enable,
    input wire logic i_inject,
    output jllt_pkg::jllt_char_t [LANES-1:0] o_char // decoded chars
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // multiframe clock, link state and characters
    // ************************************************************
    int lmfc = 0;
    int mode = 0;
    int ilas_mf = 0;
    logic ref_d = 1'b0;
    logic sync_d = 1'b1;
    logic first = 1'b0;
    logic last;
    logic mfl;
    assign last = (lmfc % F == F - 1);
    assign mfl = (lmfc == F * K - 1);

    always @(posedge i_clk) begin
        ref_d <= i_sysref;
        sync_d <= i_sync_n;
        lmfc <= ((i_sysref && !ref_d) || mfl) ? 0 : lmfc + 1;
        if (mode == 3 && last) begin
            first <= 1'b0;
        end
        if (!i_sync_n) begin
            mode <= 0;
        end else if (mode == 0 && !sync_d) begin
            mode <= 1;
        end else if (mode == 1 && mfl) begin
            mode <= 2;
            ilas_mf <= 0;
        end else if (mode == 2 && mfl) begin
            ilas_mf <= ilas_mf + 1;
            if (ilas_mf == 3) begin
                mode <= 3;
                first <= 1'b1;
            end
        end
    end

    always_comb begin
        for (int l = 0; l < LANES; l++) begin
            if (mode < 2) begin
                o_char[l] = {1'b1, jllt_pkg::CHAR_COMMA};
            end else if (mode == 2 && (lmfc == 0 || mfl)) begin
                o_char[l] = {1'b1, mfl ? jllt_pkg::CHAR_MF_ALIGN
                                       : jllt_pkg::CHAR_ILAS_START};
            end else if (mode == 2) begin
                o_char[l] = {1'b0, ilas_mf == 1 ? 8'(F) : 8'(lmfc)};
            end else if (i_inject && lmfc % F == 0) begin
                o_char[l] = {1'b1, jllt_pkg::CHAR_FR_ALIGN};
            end else if (!last) begin
                o_char[l] = {1'b0, 8'h20 + 8'(l)};
            end else if (i_scramble_enable || !first) begin
                o_char[l] = {1'b1, mfl ? jllt_pkg::CHAR_MF_ALIGN
                                       : jllt_pkg::CHAR_FR_ALIGN};
            end else begin
                o_char[l] = {1'b0, 8'hA5};
            end
        end
    end
endmodule // jllt_tx_model

// >>> testbench/jllt_rx_ctrl_tb.sv
// Purpose: self-checking bench of the link receive controller
// Assumes: transmitter model on the lanes, one sysref pulse per bring-up
// Notes: unscrambled bring-up, misalignment, then scrambled bring-up
module jllt_rx_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // stimulus, checks and scenarios
    // ************************************************************
    localparam int LANES = 2;
    localparam int F = 2;
    localparam int K = 16;
    localparam int ERR_LIMIT = 4;
    logic i_sys_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_sysref = 1'b0;
    logic i_scramble_enable = 1'b0;
    logic inject = 1'b0;
    jllt_pkg::jllt_char_t [LANES-1:0] rx_char;
    logic o_sync_n, o_sysref_req, o_link_up, o_valid;
    logic o_frame_end, o_mf_end, o_align_err;
    logic [LANES-1:0][7:0] o_data;
    int fails = 0;
    int checks_done = 0;

    jllt_rx_ctrl #(.LANES(LANES), .F(F), .K(K), .BUF_DEPTH(64),
        .ERR_LIMIT(ERR_LIMIT)) u_jllt_rx_ctrl (
        .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_sysref(i_sysref),
        .i_scramble_enable(i_scramble_enable), .i_rx_char(rx_char),
        .o_sync_n(o_sync_n), .o_sysref_req(o_sysref_req),
        .o_link_up(o_link_up), .o_valid(o_valid), .o_data(o_data),
        .o_frame_end(o_frame_end), .o_mf_end(o_mf_end),
        .o_align_err(o_align_err));
    jllt_tx_model #(.LANES(LANES), .F(F), .K(K)) u_jllt_tx_model (
        .i_clk(i_sys_clk), .i_sysref(i_sysref), .i_sync_n(o_sync_n),
        .i_scramble_enable(i_scramble_enable), .i_inject(inject),
        .o_char(rx_char));

    initial begin
        forever #25 i_sys_clk = ~i_sys_clk;
    end

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        if (fails == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic bring_up(input logic scramble_enable);
        @(posedge i_sys_clk);
        i_scramble_enable <= scramble_enable;
        i_sysref <= 1'b1;
        @(posedge i_sys_clk);
        i_sysref <= 1'b0;
        for (int n = 0; n < 20 && o_sync_n !== 1'b0; n++) @(negedge i_sys_clk);
        check("sync request", 8'(o_sync_n), 8'h00);
        for (int n = 0; n < 99 && o_sync_n !== 1'b1; n++) @(negedge i_sys_clk);
        check("sync release", 8'(o_sync_n), 8'h01);
        for (int n = 0; n < 600 && o_valid !== 1'b1; n++) @(negedge i_sys_clk);
        check("link up", 8'({o_valid, o_link_up}), 8'h03);
    endtask

    task automatic check_data(input logic scramble_enable);
        int mfs;
        logic [7:0] exp;
        logic fe;
        logic me;
        mfs = 0;
        for (int pos = 1; pos <= 3 * F * K; pos++) begin
            @(negedge i_sys_clk);
            fe = (pos % F == F - 1);
            me = (pos % (F * K) == F * K - 1);
            check("valid", 8'({o_valid, o_align_err}), 8'h02);
            check("frame marks", 8'({o_frame_end, o_mf_end}), 8'({fe, me}));
            mfs += int'(o_mf_end === 1'b1);
            for (int l = 0; l < LANES; l++) begin
                exp = me ? 8'h7C : 8'hFC;
                exp = !scramble_enable ? 8'hA5 : exp;
                exp = !fe ? 8'h20 + 8'(l) : exp;
                check("lane octet", o_data[l], exp);
            end
        end
        check("multiframes", 8'(mfs), 8'h03);
    endtask

    task automatic misalign();
        int errs;
        int reqs;
        errs = 0;
        reqs = 0;
        for (int i = 0; i < 100; i++) begin
            @(posedge i_sys_clk);
            inject <= (i < 7 * ERR_LIMIT) && (i % 7 < F);
            @(negedge i_sys_clk);
            errs += int'(o_align_err === 1'b1);
            reqs += int'(o_sysref_req === 1'b1);
        end
        check("error pulses", 8'(errs), 8'(ERR_LIMIT));
        check("sysref request", 8'(reqs), 8'h01);
        check("link dropped", 8'({o_sync_n, o_link_up}), 8'h00);
        check("commas again", rx_char[0].octet, jllt_pkg::CHAR_COMMA);
    endtask

    initial begin
        repeat (12) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        check("k range", 8'(K >= (16 + F) / F && K <= 1024 / F), 8'h01);
        repeat (40) @(negedge i_sys_clk);
        check("idle sync", 8'({o_sync_n, o_valid}), 8'h02);
        bring_up(1'b0);
        check_data(1'b0);
        misalign();
        bring_up(1'b1);
        check_data(1'b1);
        complete_run();
    end

    initial begin
        #200000;
        fails++;
        complete_run();
    end
endmodule // jllt_rx_ctrl_tb

bind jllt_rx_ctrl jllt_rx_ctrl_properties #(
    .LANES(LANES), .F(F), .K(K), .ERR_LIMIT(ERR_LIMIT)
) u_jllt_rx_ctrl_properties (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_sysref(i_sysref),
    .i_scramble_enable(i_scramble_enable), .i_rx_char(i_rx_char),
    .o_sync_n(o_sync_n), .o_sysref_req(o_sysref_req),
    .o_link_up(o_link_up), .o_valid(o_valid), .o_data(o_data),
    .o_frame_end(o_frame_end), .o_mf_end(o_mf_end),
    .o_align_err(o_align_err)
);
